/* File: hdl/atctl_pkg.sv */
// package: port addresses, field positions, reset values and types of the cycle timing control registers
package atctl_pkg;
  localparam logic [7:0] ERR_CTRL_ADDR = 8'h61;
  localparam logic [7:0] SPEED_ADDR = 8'h63;
  localparam logic [7:0] NMI_MASK_ADDR = 8'h70;
  localparam logic [7:0] TIMING_PTR_ADDR = 8'h72;
  localparam logic [7:0] TIMING_DATA_ADDR = 8'h73;
  localparam logic [7:0] BUSY_CLR_ADDR = 8'hF0;
  localparam logic [7:0] COP_RST_ADDR = 8'hF1;
  // error control field positions
  localparam int ERR_PARITY_EN_BIT = 2;
  localparam int ERR_CHANNEL_EN_BIT = 3;
  localparam int ERR_CHANNEL_STAT_BIT = 6;
  localparam int ERR_PARITY_STAT_BIT = 7;
  // speed select field positions
  localparam int SPD_STOP_BIT = 2;
  localparam int SPD_LOCK_BIT = 6;
  localparam int SPD_GATE_BIT = 7;
  localparam logic [7:0] SPEED_RESET = 8'h80;
  localparam int NMI_MASK_BIT = 7;
  localparam logic [7:0] NMI_MASK_RESET = 8'h80;
  // enhanced option bits
  localparam int ENH_HOLD_BIT = 2;
  localparam int ENH_ROM_BIT = 3;
  localparam int ENH_DIV_BIT = 3;
  localparam int ENH_RESERVED_BIT = 1;
  // timing register numbers
  localparam logic [3:0] TREG_STROBE_DELAY = 4'h0;
  localparam logic [3:0] TREG_STROBE_WIDTH = 4'h1;
  localparam logic [3:0] TREG_NARROW_CMD = 4'h3;
  localparam logic [3:0] TREG_NARROW_WAIT = 4'h4;
  localparam logic [3:0] TREG_WIDE_IO_WAIT = 4'h5;
  localparam logic [3:0] TREG_WIDE_MEM_CMD = 4'h6;
  localparam logic [3:0] TREG_WIDE_MEM_WAIT = 4'h7;
  localparam logic [3:0] TREG_ZERO_WAIT_MIN = 4'h8;
  localparam logic [3:0] TREG_LOCAL_RD_WAIT = 4'h9;
  localparam logic [3:0] TREG_LOCAL_WR_WAIT = 4'hA;
  localparam logic [3:0] TREG_LOCAL_IO_CMD = 4'hC;
  localparam logic [3:0] TREG_ENHANCED = 4'hD;
  // timing register reset values
  localparam logic [1:0] STROBE_DELAY_RESET = 2'h0;
  localparam logic [3:0] STROBE_WIDTH_RESET = 4'h1;
  localparam logic [3:0] NARROW_CMD_RESET = 4'h1;
  localparam logic [3:0] NARROW_WAIT_RESET = 4'h4;
  localparam logic [3:0] WIDE_IO_WAIT_RESET = 4'h1;
  localparam logic [3:0] WIDE_MEM_CMD_RESET = 4'h0;
  localparam logic [3:0] WIDE_MEM_WAIT_RESET = 4'h1;
  localparam logic [3:0] ZERO_WAIT_MIN_RESET = 4'h0;
  localparam logic [3:0] LOCAL_RD_WAIT_RESET = 4'h1;
  localparam logic [3:0] LOCAL_WR_WAIT_RESET = 4'h1;
  localparam logic [3:0] LOCAL_IO_CMD_RESET = 4'h1;
  localparam logic [3:0] ENHANCED_RESET = 4'h0;
  // clock periods in wait-state and divider units
  localparam int WAIT_STATE_CLOCKS = 2;
  localparam logic [2:0] BUS_DIV_FAST = 3'h6;
  localparam logic [3:0] DMA_DIV_FAST = 4'hC;
  localparam logic [2:0] BUS_DIV_NORMAL = 3'h2;
  localparam logic [3:0] DMA_DIV_NORMAL = 4'h4;
  localparam int COP_RESET_NS = 100;
  localparam int CLOCK_NS = 10;
  localparam int COP_RESET_CYCLES = (COP_RESET_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [3:0] COP_RESET_COUNT = 4'(COP_RESET_CYCLES);

  typedef struct packed {
    logic [1:0] strobe_delay;
    logic [3:0] strobe_width;
    logic [3:0] narrow_cmd_delay;
    logic [3:0] narrow_wait_states;
    logic [3:0] wide_io_wait_states;
    logic [3:0] wide_mem_cmd_delay;
    logic [3:0] wide_mem_wait_states;
    logic [3:0] zero_wait_minimum;
    logic [3:0] local_read_wait_states;
    logic [3:0] local_write_wait_states;
    logic [3:0] local_io_cmd_delay;
    logic [3:0] enhanced_options;
  } atctl_timing_t;

  typedef struct packed {
    logic [4:0] cmd_delay;
    logic [5:0] wait_clocks;
    logic [5:0] zero_wait_clocks;
    logic extra_hold;
    logic rom_select;
  } atctl_cycle_t;
endpackage

/* File: hdl/atctl_regs.sv */
// module: cycle timing control registers behind cpu i/o ports
`timescale 1ns/1ns
module atctl_regs
  import atctl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic [7:0] IO_RDATA_OE,
  input wire logic PARITY_FAIL_INPUT,
  input wire logic IO_CHANNEL_CHECK_N,
  input wire logic ONBOARD_SELECT,
  input wire logic MEM_CYCLE,
  input wire logic WRITE_CYCLE,
  input wire logic IO_WIDE_ACK,
  input wire logic MEM_WIDE_ACK,
  input wire logic COPROC_WINDOW_SELECT,
  input wire logic COPROC_ERROR_N,
  input wire logic COPROC_BUSY_N,
  input wire logic HIGH_SPEED,
  output atctl_timing_t TIMING,
  output atctl_cycle_t CYCLE,
  output logic ROM_CHIP_SELECT,
  output logic PARITY_CHECK_QUALIFIED,
  output logic CLOCK_STOP,
  output logic [7:0] SPEED_SETTING,
  output logic NMI_MASK,
  output logic BUS_CLOCK_OUT,
  output logic DMA_CLOCK_OUT,
  output logic CPU_BUSY_OUT_N,
  output logic COPROC_RESET
);

  logic [1:0] parity_sync_reg;
  logic [1:0] check_sync_reg;
  logic [1:0] err_sync_reg;
  logic [1:0] busy_sync_reg;
  logic [7:0] err_ctrl_reg;
  logic parity_stat_reg;
  logic [7:0] speed_reg;
  logic [7:0] nmi_reg;
  logic [3:0] pointer_reg;
  atctl_timing_t timing_reg;
  logic busy_latch_reg;
  logic [3:0] cop_rst_cnt_reg;
  logic [2:0] bus_div_reg;
  logic [3:0] dma_div_reg;
  logic bus_clk_reg;
  logic dma_clk_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_oe_reg;
  logic wr_err;
  logic wr_speed;
  logic wr_data;
  logic wr_busy_clr;
  logic wr_cop_rst;
  logic parity_en;
  logic fast_div;
  logic [2:0] bus_half;
  logic [3:0] dma_half;
  logic parity_seen;

  assign wr_err = IO_WR && (IO_ADDR == ERR_CTRL_ADDR);
  assign wr_speed = IO_WR && (IO_ADDR == SPEED_ADDR);
  assign wr_data = IO_WR && (IO_ADDR == TIMING_DATA_ADDR);
  assign wr_busy_clr = IO_WR && (IO_ADDR == BUSY_CLR_ADDR);
  assign wr_cop_rst = IO_WR && (IO_ADDR == COP_RST_ADDR);
  assign parity_en = err_ctrl_reg[ERR_PARITY_EN_BIT];

  // two-stage synchronisers for pin inputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      parity_sync_reg <= 2'h0;
      check_sync_reg <= 2'h3;
      err_sync_reg <= 2'h3;
      busy_sync_reg <= 2'h3;
    end else begin
      parity_sync_reg <= {parity_sync_reg[0], PARITY_FAIL_INPUT};
      check_sync_reg <= {check_sync_reg[0], IO_CHANNEL_CHECK_N};
      err_sync_reg <= {err_sync_reg[0], COPROC_ERROR_N};
      busy_sync_reg <= {busy_sync_reg[0], COPROC_BUSY_N};
    end
  end

  // error control masks, both disabled at reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      err_ctrl_reg <= 8'h00;
    end else if (wr_err) begin
      err_ctrl_reg <= IO_WDATA;
    end
  end

  // parity failures on on-board memory reads not from rom cycles latch while enabled; clearing the enable clears
  assign parity_seen = parity_sync_reg[1] && ONBOARD_SELECT && MEM_CYCLE && !WRITE_CYCLE && !ROM_CHIP_SELECT;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      parity_stat_reg <= 1'b0;
    end else if (parity_en && parity_seen) begin
      parity_stat_reg <= 1'b1;
    end else if (!parity_en) begin
      parity_stat_reg <= 1'b0;
    end
  end

  // read of error port: only bits 6 and 7 are driven
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
      rdata_oe_reg <= 8'h00;
    end else if (IO_RD && (IO_ADDR == ERR_CTRL_ADDR)) begin
      rdata_reg <= 8'h00;
      rdata_reg[ERR_PARITY_STAT_BIT] <= parity_stat_reg;
      rdata_reg[ERR_CHANNEL_STAT_BIT] <= err_ctrl_reg[ERR_CHANNEL_EN_BIT] && !check_sync_reg[1];
      rdata_oe_reg <= 8'hC0;
    end else begin
      rdata_reg <= 8'h00;
      rdata_oe_reg <= 8'h00;
    end
  end
  assign IO_RDATA = rdata_reg;
  assign IO_RDATA_OE = rdata_oe_reg;

  // speed select: lock bit gates later writes
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      speed_reg <= SPEED_RESET;
    end else if (wr_speed && !speed_reg[SPD_LOCK_BIT] && !IO_WDATA[SPD_GATE_BIT]) begin
      speed_reg <= IO_WDATA;
    end else if (wr_speed && !IO_WDATA[SPD_GATE_BIT]) begin
      speed_reg[SPD_LOCK_BIT] <= IO_WDATA[SPD_LOCK_BIT];
    end
  end
  assign SPEED_SETTING = speed_reg;
  assign CLOCK_STOP = speed_reg[SPD_STOP_BIT];

  // nmi mask
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      nmi_reg <= NMI_MASK_RESET;
    end else if (IO_WR && (IO_ADDR == NMI_MASK_ADDR)) begin
      nmi_reg <= IO_WDATA;
    end
  end
  assign NMI_MASK = nmi_reg[NMI_MASK_BIT];

  // pointer register number from bits 7,6,3,2
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pointer_reg <= 4'h0;
    end else if (IO_WR && (IO_ADDR == TIMING_PTR_ADDR)) begin
      pointer_reg <= {IO_WDATA[7], IO_WDATA[6], IO_WDATA[3], IO_WDATA[2]};
    end
  end

  // indexed timing registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      timing_reg.strobe_delay <= STROBE_DELAY_RESET;
      timing_reg.strobe_width <= STROBE_WIDTH_RESET;
      timing_reg.narrow_cmd_delay <= NARROW_CMD_RESET;
      timing_reg.narrow_wait_states <= NARROW_WAIT_RESET;
      timing_reg.wide_io_wait_states <= WIDE_IO_WAIT_RESET;
      timing_reg.wide_mem_cmd_delay <= WIDE_MEM_CMD_RESET;
      timing_reg.wide_mem_wait_states <= WIDE_MEM_WAIT_RESET;
      timing_reg.zero_wait_minimum <= ZERO_WAIT_MIN_RESET;
      timing_reg.local_read_wait_states <= LOCAL_RD_WAIT_RESET;
      timing_reg.local_write_wait_states <= LOCAL_WR_WAIT_RESET;
      timing_reg.local_io_cmd_delay <= LOCAL_IO_CMD_RESET;
      timing_reg.enhanced_options <= ENHANCED_RESET;
    end else if (wr_data && !speed_reg[SPD_LOCK_BIT]) begin
      case (pointer_reg)
        TREG_STROBE_DELAY: timing_reg.strobe_delay <= IO_WDATA[1:0];
        TREG_STROBE_WIDTH: begin
          if (IO_WDATA[3:0] != 4'h0) begin
            timing_reg.strobe_width <= IO_WDATA[3:0];
          end
        end
        TREG_NARROW_CMD: timing_reg.narrow_cmd_delay <= IO_WDATA[3:0];
        TREG_NARROW_WAIT: timing_reg.narrow_wait_states <= IO_WDATA[3:0];
        TREG_WIDE_IO_WAIT: timing_reg.wide_io_wait_states <= IO_WDATA[3:0];
        TREG_WIDE_MEM_CMD: timing_reg.wide_mem_cmd_delay <= IO_WDATA[3:0];
        TREG_WIDE_MEM_WAIT: timing_reg.wide_mem_wait_states <= IO_WDATA[3:0];
        TREG_ZERO_WAIT_MIN: timing_reg.zero_wait_minimum <= IO_WDATA[3:0];
        TREG_LOCAL_RD_WAIT: timing_reg.local_read_wait_states <= IO_WDATA[3:0];
        TREG_LOCAL_WR_WAIT: timing_reg.local_write_wait_states <= IO_WDATA[3:0];
        TREG_LOCAL_IO_CMD: timing_reg.local_io_cmd_delay <= IO_WDATA[3:0];
        TREG_ENHANCED: timing_reg.enhanced_options <= {IO_WDATA[7], IO_WDATA[6], 1'b0, IO_WDATA[2]};
        default: timing_reg <= timing_reg;
      endcase
    end
  end
  assign TIMING = timing_reg;

  // options packed as {bit7, bit6, 0, bit2}
  assign ROM_CHIP_SELECT = timing_reg.enhanced_options[ENH_ROM_BIT - 1] && COPROC_WINDOW_SELECT;
  assign PARITY_CHECK_QUALIFIED = parity_en && !ROM_CHIP_SELECT;

  // cycle parameters selected by cycle type
  always_comb begin
    CYCLE = '0;
    CYCLE.zero_wait_clocks = 6'(timing_reg.zero_wait_minimum * WAIT_STATE_CLOCKS);
    CYCLE.extra_hold = timing_reg.enhanced_options[0] && HIGH_SPEED && !ONBOARD_SELECT;
    CYCLE.rom_select = ROM_CHIP_SELECT;
    if (ONBOARD_SELECT && MEM_CYCLE) begin
      CYCLE.cmd_delay = 5'h00;
      CYCLE.wait_clocks = 6'((WRITE_CYCLE ? timing_reg.local_write_wait_states
                                          : timing_reg.local_read_wait_states) * WAIT_STATE_CLOCKS);
    end else if (ONBOARD_SELECT) begin
      CYCLE.cmd_delay = {1'b0, timing_reg.local_io_cmd_delay};
      CYCLE.wait_clocks = 6'((WRITE_CYCLE ? timing_reg.local_write_wait_states
                                          : timing_reg.local_read_wait_states) * WAIT_STATE_CLOCKS);
    end else if (MEM_CYCLE && MEM_WIDE_ACK) begin
      CYCLE.cmd_delay = {1'b0, timing_reg.wide_mem_cmd_delay};
      CYCLE.wait_clocks = 6'(timing_reg.wide_mem_wait_states * WAIT_STATE_CLOCKS);
    end else if (!MEM_CYCLE && IO_WIDE_ACK) begin
      CYCLE.cmd_delay = {1'b0, timing_reg.narrow_cmd_delay};
      CYCLE.wait_clocks = 6'(timing_reg.wide_io_wait_states * WAIT_STATE_CLOCKS);
    end else begin
      CYCLE.cmd_delay = {1'b0, timing_reg.narrow_cmd_delay};
      CYCLE.wait_clocks = 6'(timing_reg.narrow_wait_states * WAIT_STATE_CLOCKS);
    end
  end

  // bus and dma clock dividers, frozen while stopped
  assign fast_div = timing_reg.enhanced_options[ENH_DIV_BIT] && HIGH_SPEED;
  assign bus_half = fast_div ? 3'(BUS_DIV_FAST >> 1) : 3'(BUS_DIV_NORMAL >> 1);
  assign dma_half = fast_div ? 4'(DMA_DIV_FAST >> 1) : 4'(DMA_DIV_NORMAL >> 1);
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bus_div_reg <= 3'h0;
      bus_clk_reg <= 1'b0;
    end else if (!CLOCK_STOP) begin
      if (bus_div_reg >= bus_half - 3'h1) begin
        bus_div_reg <= 3'h0;
        bus_clk_reg <= !bus_clk_reg;
      end else begin
        bus_div_reg <= bus_div_reg + 3'h1;
      end
    end
  end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dma_div_reg <= 4'h0;
      dma_clk_reg <= 1'b0;
    end else if (!CLOCK_STOP) begin
      if (dma_div_reg >= dma_half - 4'h1) begin
        dma_div_reg <= 4'h0;
        dma_clk_reg <= !dma_clk_reg;
      end else begin
        dma_div_reg <= dma_div_reg + 4'h1;
      end
    end
  end
  assign BUS_CLOCK_OUT = bus_clk_reg;
  assign DMA_CLOCK_OUT = dma_clk_reg;

  // coprocessor error latch: error while busy sets, port write releases
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      busy_latch_reg <= 1'b0;
    end else if (!err_sync_reg[1] && !busy_sync_reg[1]) begin
      busy_latch_reg <= 1'b1;
    end else if (wr_busy_clr || COPROC_RESET) begin
      busy_latch_reg <= 1'b0;
    end
  end
  assign CPU_BUSY_OUT_N = busy_sync_reg[1] && !busy_latch_reg;

  // coprocessor reset pulse, also held during system reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cop_rst_cnt_reg <= COP_RESET_COUNT;
    end else if (wr_cop_rst) begin
      cop_rst_cnt_reg <= COP_RESET_COUNT;
    end else if (cop_rst_cnt_reg != 4'h0) begin
      cop_rst_cnt_reg <= cop_rst_cnt_reg - 4'h1;
    end
  end
  assign COPROC_RESET = (cop_rst_cnt_reg != 4'h0);

  // assertions
  // counts unbroken high cycles of the coprocessor reset since the last port write
  logic [3:0] cop_len_reg;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cop_len_reg <= 4'h0;
    end else if (wr_cop_rst || !COPROC_RESET) begin
      cop_len_reg <= 4'h0;
    end else if (cop_len_reg != 4'hF) begin
      cop_len_reg <= cop_len_reg + 4'h1;
    end
  end

  sequence s_cop_write;
    wr_cop_rst;
  endsequence
  sequence s_cop_pulse;
    COPROC_RESET ##9 (COPROC_RESET && cop_len_reg == COP_RESET_COUNT - 4'h1) ##1 !COPROC_RESET;
  endsequence

  property p_cop_reset;
    @(posedge CLOCK) disable iff (!RST_N) s_cop_write |=> s_cop_pulse;
  endproperty
  a_cop_reset: assert property (p_cop_reset) else $error("coprocessor reset pulse wrong");

  property p_busy_release;
    @(posedge CLOCK) disable iff (!RST_N) (wr_busy_clr && err_sync_reg[1]) |=> !busy_latch_reg;
  endproperty
  a_busy_release: assert property (p_busy_release) else $error("busy not released");

  property p_read_lanes;
    @(posedge CLOCK) disable iff (!RST_N) (IO_RD && IO_ADDR == ERR_CTRL_ADDR) |=> IO_RDATA_OE == 8'hC0;
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("wrong read lanes");

  property p_locked_speed;
    @(posedge CLOCK) disable iff (!RST_N)
      (wr_speed && speed_reg[SPD_LOCK_BIT]) |=> speed_reg[SPD_STOP_BIT] == $past(speed_reg[SPD_STOP_BIT]);
  endproperty
  a_locked_speed: assert property (p_locked_speed) else $error("locked speed changed");

  property p_pointer_write;
    @(posedge CLOCK) disable iff (!RST_N)
      (wr_data && !speed_reg[SPD_LOCK_BIT] && pointer_reg == TREG_NARROW_WAIT)
        |=> timing_reg.narrow_wait_states == $past(IO_WDATA[3:0]);
  endproperty
  a_pointer_write: assert property (p_pointer_write) else $error("indexed write missed");

  property p_unused_index;
    @(posedge CLOCK) disable iff (!RST_N)
      (wr_data && (pointer_reg == 4'h2 || pointer_reg == 4'hB)) |=> $stable(timing_reg);
  endproperty
  a_unused_index: assert property (p_unused_index) else $error("unused index altered");

  property p_wait_double;
    @(posedge CLOCK) disable iff (!RST_N)
      (!ONBOARD_SELECT && !MEM_CYCLE && !IO_WIDE_ACK)
        |-> CYCLE.wait_clocks == 6'(timing_reg.narrow_wait_states) * 6'h2;
  endproperty
  a_wait_double: assert property (p_wait_double) else $error("wait state not two clocks");

  property p_parity_clear;
    @(posedge CLOCK) disable iff (!RST_N) (!parity_en && !parity_seen) ##1 !parity_en |-> !parity_stat_reg;
  endproperty
  a_parity_clear: assert property (p_parity_clear) else $error("parity status not cleared");

  property p_onboard_zero;
    @(posedge CLOCK) disable iff (!RST_N) (ONBOARD_SELECT && MEM_CYCLE) |-> CYCLE.cmd_delay == 5'h00;
  endproperty
  a_onboard_zero: assert property (p_onboard_zero) else $error("on-board delay nonzero");

  property p_stop_freeze;
    @(posedge CLOCK) disable iff (!RST_N) CLOCK_STOP ##1 CLOCK_STOP |-> $stable(bus_clk_reg);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("bus clock ran while stopped");

endmodule // atctl_regs

/* File: verification/atctl_host.sv */
// host cpu model issuing single-cycle i/o writes and reads
`timescale 1ns/1ns
module atctl_host (
  input wire logic clock,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_oe,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
  end
  // request held from one falling edge to the next, released lines show inverted values
  task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    io_addr = addr;
    io_wdata = data;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    io_addr = ~addr;
    io_wdata = ~data;
  endtask
  task automatic io_read(input logic [7:0] addr, output logic [7:0] data, output logic [7:0] oe);
    @(negedge clock);
    io_addr = addr;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    io_addr = ~addr;
    data = rdata;
    oe = rdata_oe;
  endtask
endmodule // atctl_host

/* File: verification/test_atctl_regs.sv */
// testbench for the cycle timing control registers
`timescale 1ns/1ns
module test_atctl_regs
  import atctl_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, io_wr, io_rd, par_fail = 1'b0, chk_n = 1'b1, onb = 1'b0, mem = 1'b0;
  logic wr_cyc = 1'b0, io_ack = 1'b0, mem_ack = 1'b0, win_sel = 1'b0, err_n = 1'b1, busy_n = 1'b1, hs = 1'b0;
  logic [7:0] io_addr, io_wdata, rdata, rdata_oe, speed;
  logic rom_cs, par_q, clk_stop, nmi, bus_clk, dma_clk, cpu_busy_n, cop_rst;
  atctl_timing_t timing;
  atctl_cycle_t cycle;
  int miscompares = 0;
  int checks_done = 0;
  always #5 clock = ~clock;
  atctl_regs atctl_regs_inst (.CLOCK(clock), .RST_N(rst_n), .IO_WR(io_wr), .IO_RD(io_rd), .IO_ADDR(io_addr),
    .IO_WDATA(io_wdata), .IO_RDATA(rdata), .IO_RDATA_OE(rdata_oe), .PARITY_FAIL_INPUT(par_fail),
    .IO_CHANNEL_CHECK_N(chk_n), .ONBOARD_SELECT(onb), .MEM_CYCLE(mem), .WRITE_CYCLE(wr_cyc), .IO_WIDE_ACK(io_ack),
    .MEM_WIDE_ACK(mem_ack), .COPROC_WINDOW_SELECT(win_sel), .COPROC_ERROR_N(err_n), .COPROC_BUSY_N(busy_n),
    .HIGH_SPEED(hs), .TIMING(timing), .CYCLE(cycle), .ROM_CHIP_SELECT(rom_cs), .PARITY_CHECK_QUALIFIED(par_q),
    .CLOCK_STOP(clk_stop), .SPEED_SETTING(speed), .NMI_MASK(nmi), .BUS_CLOCK_OUT(bus_clk),
    .DMA_CLOCK_OUT(dma_clk), .CPU_BUSY_OUT_N(cpu_busy_n), .COPROC_RESET(cop_rst));
  atctl_host atctl_host_inst (.clock(clock), .rdata(rdata), .rdata_oe(rdata_oe), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    atctl_host_inst.io_write(a, d);
  endtask
  task automatic treg(input logic [3:0] i, input logic [7:0] d);
    wr(TIMING_PTR_ADDR, {i[3], i[2], 2'h0, i[1], i[0], 2'h0});
    wr(TIMING_DATA_ADDR, d);
  endtask
  task automatic cyc(input logic [4:0] kind, input logic [4:0] cmd, input logic [5:0] wt);
    @(negedge clock);
    {onb, mem, wr_cyc, io_ack, mem_ack} = kind;
    #1;
    chk("command delay", cmd, cycle.cmd_delay);
    chk("wait clocks", wt, cycle.wait_clocks);
  endtask
  task automatic edges(input int n, output int b, output int d);
    logic pb, pd;
    b = 0;
    d = 0;
    pb = bus_clk;
    pd = dma_clk;
    repeat (n) begin
      @(negedge clock);
      b += int'(bus_clk & ~pb);
      d += int'(dma_clk & ~pd);
      pb = bus_clk;
      pd = dma_clk;
    end
  endtask
  task automatic test_reset_defaults;
    chk("timing defaults", {2'h0, 4'h1, 4'h1, 4'h4, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1, 4'h1, 4'h1, 4'h0}, timing);
    chk("speed reset", 8'h80, speed);
    chk("nmi reset", 1'h1, nmi);
    chk("stop reset", 1'h0, clk_stop);
  endtask
  task automatic test_timing_bank;
    logic [3:0] idx [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC};
    logic [45:0] exp = {2'h3, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'h0};
    for (int k = 0; k < 11; k++) begin
      treg(idx[k], (idx[k] < 4'h2) ? 8'h03 : {4'h0, idx[k] + 4'h2});
    end
    chk("timing bank", exp, timing);
    treg(4'h2, 8'h0F);
    treg(4'hB, 8'h0F);
    treg(4'hE, 8'h0F);
    treg(4'hF, 8'h0F);
    treg(4'h1, 8'h00);
    chk("timing after unused", exp, timing);
  endtask
  task automatic test_cycle_select;
    cyc(5'h08, 5'h05, 6'h0C);
    cyc(5'h09, 5'h08, 6'h12);
    cyc(5'h02, 5'h05, 6'h0E);
    cyc(5'h18, 5'h00, 6'h16);
    cyc(5'h1C, 5'h00, 6'h18);
    cyc(5'h10, 5'h0E, 6'h16);
    chk("zero wait clocks", 6'h14, cycle.zero_wait_clocks);
  endtask
  task automatic test_error_port;
    logic [7:0] d, oe;
    wr(ERR_CTRL_ADDR, 8'h0C);
    @(negedge clock);
    chk_n = 1'b0;
    repeat (4) @(negedge clock);
    atctl_host_inst.io_read(ERR_CTRL_ADDR, d, oe);
    chk("channel status", 1'h1, d[6]);
    chk("read enable", 8'hC0, oe);
    {onb, mem, wr_cyc, io_ack, mem_ack} = 5'h18;
    par_fail = 1'b1;
    repeat (4) @(negedge clock);
    par_fail = 1'b0;
    wr(ERR_CTRL_ADDR, 8'h04);
    atctl_host_inst.io_read(ERR_CTRL_ADDR, d, oe);
    chk("parity and masked channel", 2'h2, d[7:6]);
    chk_n = 1'b1;
    wr(ERR_CTRL_ADDR, 8'h00);
    wr(ERR_CTRL_ADDR, 8'h0C);
    atctl_host_inst.io_read(ERR_CTRL_ADDR, d, oe);
    chk("parity cleared", 1'h0, d[7]);
    atctl_host_inst.io_read(SPEED_ADDR, d, oe);
    chk("write-only port enable", 8'h00, oe);
  endtask
  task automatic test_options_clocks;
    int b, d;
    @(negedge clock);
    hs = 1'b1;
    {onb, mem, wr_cyc, io_ack, mem_ack} = 5'h08;
    edges(120, b, d);
    chk("normal dividers", 1'h1, (b inside {[59:61]}) && (d inside {[29:31]}));
    treg(4'hD, 8'hC4);
    win_sel = 1'b1;
    #1;
    chk("rom select", 3'h5, {rom_cs, par_q, cycle.rom_select});
    chk("extra hold", 1'h1, cycle.extra_hold);
    edges(120, b, d);
    chk("fast dividers", 1'h1, (b inside {[19:21]}) && (d inside {[9:11]}));
    win_sel = 1'b0;
    #1;
    chk("rom released", 3'h2, {rom_cs, par_q, cycle.rom_select});
    treg(4'hD, 8'h00);
  endtask
  task automatic test_speed_lock;
    int b, d;
    wr(SPEED_ADDR, 8'h84);
    chk("gated speed write", 9'h080, {clk_stop, speed});
    wr(SPEED_ADDR, 8'h04);
    edges(24, b, d);
    chk("stopped clocks", 2'h3, {clk_stop, b == 0 && d == 0});
    wr(SPEED_ADDR, 8'h40);
    treg(4'h4, 8'h02);
    chk("locked timing", 4'h6, timing.narrow_wait_states);
    wr(SPEED_ADDR, 8'h04);
    chk("locked stop", 2'h0, {clk_stop, speed[6]});
  endtask
  task automatic test_coproc;
    int n = 0;
    @(negedge clock);
    {err_n, busy_n} = 2'h0;
    repeat (4) @(negedge clock);
    {err_n, busy_n} = 2'h3;
    repeat (4) @(negedge clock);
    chk("busy latched", 1'h0, cpu_busy_n);
    wr(BUSY_CLR_ADDR, 8'hA5);
    @(negedge clock);
    chk("busy released", 1'h1, cpu_busy_n);
    wr(NMI_MASK_ADDR, 8'h00);
    chk("nmi mask", 1'h0, nmi);
    wr(COP_RST_ADDR, 8'h00);
    repeat (20) begin
      n += int'(cop_rst);
      @(negedge clock);
    end
    chk("coproc reset cycles", 10, n);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    $display("MISMATCH watchdog expected done seen hang");
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    test_reset_defaults();
    test_timing_bank();
    test_cycle_select();
    test_error_port();
    test_options_clocks();
    test_speed_lock();
    test_coproc();
    report_and_stop();
  end
endmodule // test_atctl_regs
